// >>> hdl/core_special_registers_params.svh
// Offsets, field positions and reset values of the special registers
// Summary of operation
// - Launch copies image into RAM from 0
// - Output register holds 32 pins; port B reserved
// - Output bit 0 drives low, 1 high
// - Output register readable, writable as either operand
// - Whole word access; mux instructions update bits
// - Keep bits 2..15, low two bits zero
// - Parameter source reads launch value; destination shadow
// - Two counters accumulate frequency per stimulus
// - Phase source live; destination shadow; write both
// - No-result effect leaves destination unmodified
`ifndef CORE_SPECIAL_REGISTERS_PARAMS_SVH
`define CORE_SPECIAL_REGISTERS_PARAMS_SVH

`define CSR_ADDR_LAUNCH_PARAMETER 9'h1f0
`define CSR_ADDR_PIN_OUTPUT_A     9'h1f4
`define CSR_ADDR_PIN_OUTPUT_B     9'h1f5
`define CSR_ADDR_PHASE_A          9'h1fc
`define CSR_ADDR_PHASE_B          9'h1fd
`define CSR_LOAD_BASE             9'h000
`define CSR_PAR_LSB               2
`define CSR_PAR_MSB               15
`define CSR_RESET_WORD            32'h0000_0000

`endif

// >>> hdl/core_special_registers_pkg.sv
// Types shared by the special register bank
package core_special_registers_pkg;
    typedef enum logic [0:0] {
        LD_IDLE = 1'b0,
        LD_COPY = 1'b1
    } load_state_t;
    typedef logic [31:0] word_t;
endpackage

// >>> hdl/core_special_registers.sv
// Special registers of one core: pin outputs, launch parameter, phase accumulators, launch loader
`timescale 1ns/1ps
`include "core_special_registers_params.svh"

module core_special_registers #(
    parameter int ADDR_W   = 9,
    parameter int RAM_WORDS = 512,
    parameter int PINS     = 32,
    parameter int COUNTERS = 2
) (
    input  wire logic                   ref_clk,       // System clock, 100 MHz
    input  wire logic                   sys_rst,       // Synchronous reset, active high
    input  wire logic                   launch_req,    // Core launch pulse
    input  wire logic [15:0]            launch_param,  // Parameter address supplied at launch
    input  wire logic [ADDR_W-1:0]      launch_len,    // Image length in words, minus one
    input  wire logic                   load_valid,    // Image word available
    input  wire logic [31:0]            load_data,     // Image word from main memory
    output logic                        load_ready,    // Loader accepts image word
    output logic                        core_run,      // Image loaded, core may execute
    input  wire logic                   rd_en,         // Operand fetch strobe
    input  wire logic [ADDR_W-1:0]      src_addr,      // Source operand address
    input  wire logic [ADDR_W-1:0]      dst_addr,      // Destination operand address
    output logic [31:0]                 src_data,      // Source operand value
    output logic [31:0]                 dst_data,      // Destination operand value
    input  wire logic                   wr_en,         // Result write strobe
    input  wire logic [ADDR_W-1:0]      wr_addr,       // Result destination address
    input  wire logic [31:0]            wr_data,       // Result value
    input  wire logic                   wr_no_result,  // No-result effect, suppresses write
    input  wire logic                   wr_mux,        // Multiplex-type bit update
    input  wire logic [31:0]            wr_mask,       // Bits touched by multiplex update
    input  wire logic [COUNTERS-1:0]    count_en,      // Counter input stimulus per counter
    input  wire logic [COUNTERS*32-1:0] freq_inc,      // Frequency increment per counter
    input  wire logic [PINS-1:0]        pin_dir,       // Pin direction, 1 = output
    output logic [PINS-1:0]             pin_o,         // Pin output level
    output logic [PINS-1:0]             pin_oe         // Pin output enable
);

    core_special_registers_pkg::load_state_t ld_state_r;
    logic [ADDR_W-1:0]             ld_addr_r;
    logic [ADDR_W-1:0]             ld_last_r;
    logic                          run_r;
    logic [31:0]                   par_r;
    logic [PINS-1:0]               outa_r;
    logic [31:0]                   phs_r [COUNTERS];
    logic [31:0]                   ram [RAM_WORDS];
    logic                          wr_go;
    logic                          ram_we;
    logic [ADDR_W-1:0]             ram_waddr;
    logic [31:0]                   ram_wdata;
    logic [ADDR_W-1:0]             phase_addr [COUNTERS];

    assign phase_addr[0] = `CSR_ADDR_PHASE_A;
    assign phase_addr[1] = `CSR_ADDR_PHASE_B;

    // Result write only when the no-result effect is absent
    assign wr_go = wr_en && !wr_no_result;

    // Launch loader: copies the image word by word from location 0
    assign load_ready = (ld_state_r == core_special_registers_pkg::LD_COPY);
    assign core_run   = run_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ld_state_r <= core_special_registers_pkg::LD_IDLE;
            ld_addr_r  <= '0;
            ld_last_r  <= '0;
            run_r      <= 1'b0;
        end else begin
            case (ld_state_r)
                core_special_registers_pkg::LD_IDLE: begin
                    if (launch_req) begin
                        ld_state_r <= core_special_registers_pkg::LD_COPY;
                        ld_addr_r  <= `CSR_LOAD_BASE;
                        ld_last_r  <= launch_len;
                        run_r      <= 1'b0;
                    end
                end
                core_special_registers_pkg::LD_COPY: begin
                    if (load_valid) begin
                        ld_addr_r <= ld_addr_r + ADDR_W'(1);
                        if (ld_addr_r == ld_last_r) begin
                            ld_state_r <= core_special_registers_pkg::LD_IDLE;
                            run_r      <= 1'b1;
                        end
                    end
                end
                default: ld_state_r <= core_special_registers_pkg::LD_IDLE;
            endcase
        end
    end

    // Launch value latched aligned; relaunch while loading is ignored
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            par_r <= `CSR_RESET_WORD;
        end else if (launch_req && ld_state_r == core_special_registers_pkg::LD_IDLE) begin
            par_r <= {16'h0000, launch_param[`CSR_PAR_MSB:`CSR_PAR_LSB], 2'b00};
        end
    end

    // Shadow RAM port: loader has priority, core is stalled while loading
    always_comb begin
        ram_we    = 1'b0;
        ram_waddr = wr_addr;
        ram_wdata = wr_data;
        if (load_ready && load_valid) begin
            ram_we    = 1'b1;
            ram_waddr = ld_addr_r;
            ram_wdata = load_data;
        end else if (wr_go && run_r && wr_addr != `CSR_ADDR_PIN_OUTPUT_A
                     && wr_addr != `CSR_ADDR_PIN_OUTPUT_B) begin
            ram_we = 1'b1;
        end
    end

    // Memory array has no reset, contents defined by the loader
    always_ff @(posedge ref_clk) begin
        if (ram_we) begin
            ram[ram_waddr] <= ram_wdata;
        end
    end

    // Pin output state; port B has no pins and no storage
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            outa_r <= '0;
        end else if (wr_go && run_r && wr_addr == `CSR_ADDR_PIN_OUTPUT_A) begin
            if (wr_mux) begin
                outa_r <= (outa_r & ~wr_mask) | (wr_data & wr_mask);
            end else begin
                outa_r <= wr_data;
            end
        end
    end

    assign pin_o  = outa_r;
    assign pin_oe = pin_dir;

    // Phase accumulators; an instruction write wins over accumulation
    generate
        for (genvar c = 0; c < COUNTERS; c++) begin : g_counter
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    phs_r[c] <= `CSR_RESET_WORD;
                end else if (wr_go && run_r && wr_addr == phase_addr[c]) begin
                    phs_r[c] <= wr_data;
                end else if (count_en[c]) begin
                    phs_r[c] <= phs_r[c] + freq_inc[c*32 +: 32];
                end
            end
        end
    endgenerate

    // Operand fetch, one cycle latency
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            src_data <= '0;
        end else if (rd_en) begin
            case (src_addr)
                `CSR_ADDR_LAUNCH_PARAMETER: src_data <= par_r;
                `CSR_ADDR_PIN_OUTPUT_A:     src_data <= outa_r;
                `CSR_ADDR_PIN_OUTPUT_B:     src_data <= '0;
                `CSR_ADDR_PHASE_A:          src_data <= phs_r[0];
                `CSR_ADDR_PHASE_B:          src_data <= phs_r[1];
                default:                    src_data <= ram[src_addr];
            endcase
        end
    end

    // Destination side sees shadows for the pseudo-registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dst_data <= '0;
        end else if (rd_en) begin
            case (dst_addr)
                `CSR_ADDR_PIN_OUTPUT_A: dst_data <= outa_r;
                `CSR_ADDR_PIN_OUTPUT_B: dst_data <= '0;
                default:                dst_data <= ram[dst_addr];
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    par_aligned_a: assert property (par_r[1:0] == 2'b00 && par_r[31:16] == 16'h0000)
        else $error("Launch parameter not long aligned");

    // Loader, launch value, output register and no-result writes
    par_capture_a: assert property (launch_req && ld_state_r == core_special_registers_pkg::LD_IDLE
        |=> par_r[15:2] == $past(launch_param[15:2]))
        else $error("Launch parameter not captured");

    par_source_a: assert property (rd_en && src_addr == `CSR_ADDR_LAUNCH_PARAMETER
        && !launch_req |=> src_data == $past(par_r))
        else $error("Parameter source read wrong");

    load_origin_a: assert property (launch_req && ld_state_r == core_special_registers_pkg::LD_IDLE
        |=> ld_addr_r == '0 && load_ready && !core_run)
        else $error("Loader does not start at zero");

    load_write_a: assert property (load_ready && load_valid
        |=> ram[$past(ld_addr_r)] == $past(load_data))
        else $error("Image word not stored at loader address");

    load_last_a: assert property (load_ready && load_valid && ld_addr_r == ld_last_r
        |=> core_run && !load_ready)
        else $error("Loader did not finish after last word");

    run_hold_a: assert property (core_run && !launch_req
        |=> core_run)
        else $error("Core run dropped without a launch");

    par_hold_a: assert property (!(launch_req && ld_state_r == core_special_registers_pkg::LD_IDLE)
        |=> $stable(par_r))
        else $error("Launch value changed without a launch");

    par_shadow_a: assert property (wr_go && run_r && wr_addr == `CSR_ADDR_LAUNCH_PARAMETER
        |=> ram[`CSR_ADDR_LAUNCH_PARAMETER] == $past(wr_data))
        else $error("Parameter write missed its shadow");

    pin_drive_a: assert property (wr_go && run_r && !wr_mux && wr_addr == `CSR_ADDR_PIN_OUTPUT_A
        && !(load_ready && load_valid) |=> pin_o == $past(wr_data))
        else $error("Pin level does not follow output bit");

    mux_update_a: assert property (wr_go && run_r && wr_mux && wr_addr == `CSR_ADDR_PIN_OUTPUT_A
        |=> (pin_o & ~$past(wr_mask)) == ($past(outa_r) & ~$past(wr_mask)))
        else $error("Multiplex update touched unselected bits");

    mux_select_a: assert property (wr_go && run_r && wr_mux && wr_addr == `CSR_ADDR_PIN_OUTPUT_A
        |=> (pin_o & $past(wr_mask)) == ($past(wr_data) & $past(wr_mask)))
        else $error("Multiplex update missed selected bits");

    no_result_a: assert property (wr_en && wr_no_result && !launch_req
        |=> $stable(outa_r) && phs_r[0] == $past(phs_r[0]) + ($past(count_en[0]) ? $past(freq_inc[31:0]) : 32'h0))
        else $error("No-result write modified destination");

    // Counters: an instruction write beats accumulation
    phase_write_a: assert property (wr_go && run_r && wr_addr == `CSR_ADDR_PHASE_A
        |=> phs_r[0] == $past(wr_data))
        else $error("Phase write did not reach accumulator");

    phase_write_b_a: assert property (wr_go && run_r && wr_addr == `CSR_ADDR_PHASE_B
        |=> phs_r[1] == $past(wr_data))
        else $error("Second phase write did not reach accumulator");

    phase_shadow_a: assert property (wr_go && run_r && wr_addr == `CSR_ADDR_PHASE_B
        |=> ram[`CSR_ADDR_PHASE_B] == $past(wr_data))
        else $error("Phase write missed its shadow");

    phase_count_a: assert property (count_en[1] && !(wr_go && run_r && wr_addr == `CSR_ADDR_PHASE_B)
        |=> phs_r[1] == $past(phs_r[1]) + $past(freq_inc[63:32]))
        else $error("Phase accumulation wrong");

    count_step_a: assert property (count_en[0] && !(wr_go && run_r && wr_addr == `CSR_ADDR_PHASE_A)
        |=> phs_r[0] == $past(phs_r[0]) + $past(freq_inc[31:0]))
        else $error("First phase accumulation wrong");

    phase_hold_a: assert property (!count_en[1] && !(wr_go && run_r && wr_addr == `CSR_ADDR_PHASE_B)
        |=> $stable(phs_r[1]))
        else $error("Phase moved without stimulus");

    // Operand reads: live values on source, shadows on destination except the live output register and port B, which reads zero
    phase_source_a: assert property (rd_en && src_addr == `CSR_ADDR_PHASE_B
        |=> src_data == $past(phs_r[1]))
        else $error("Phase source read not live");

    phase_live_a: assert property (rd_en && src_addr == `CSR_ADDR_PHASE_A
        |=> src_data == $past(phs_r[0]))
        else $error("First phase source read not live");

    out_source_a: assert property (rd_en && src_addr == `CSR_ADDR_PIN_OUTPUT_A
        |=> src_data == $past(outa_r))
        else $error("Output register source read wrong");

    out_dest_a: assert property (rd_en && dst_addr == `CSR_ADDR_PIN_OUTPUT_A
        |=> dst_data == $past(outa_r))
        else $error("Output register destination read wrong");

    pin_output_state_b_source_a: assert property (rd_en && src_addr == `CSR_ADDR_PIN_OUTPUT_B
        |=> src_data == '0)
        else $error("Reserved port source read not zero");

    pin_output_state_b_dest_a: assert property (rd_en && dst_addr == `CSR_ADDR_PIN_OUTPUT_B
        |=> dst_data == '0)
        else $error("Reserved port destination read not zero");

    dst_shadow_a: assert property (rd_en && dst_addr != `CSR_ADDR_PIN_OUTPUT_A && dst_addr != `CSR_ADDR_PIN_OUTPUT_B
        |=> dst_data == $past(ram[dst_addr]))
        else $error("Destination read did not return shadow");

    par_dest_a: assert property (rd_en && dst_addr == `CSR_ADDR_LAUNCH_PARAMETER
        |=> dst_data == $past(ram[`CSR_ADDR_LAUNCH_PARAMETER]))
        else $error("Parameter destination read not shadow");

    src_ram_a: assert property (rd_en && src_addr < `CSR_ADDR_LAUNCH_PARAMETER
        |=> src_data == $past(ram[src_addr]))
        else $error("Loaded word read back wrong");

    operand_hold_a: assert property (!rd_en
        |=> $stable(src_data) && $stable(dst_data))
        else $error("Operand value changed without a fetch");

    launch_done_c: cover property (load_ready && load_valid && ld_addr_r == ld_last_r ##1 core_run);
    phase_write_c: cover property (wr_go && run_r && wr_addr == `CSR_ADDR_PHASE_A && count_en[0]);
    mux_write_c:   cover property (wr_go && run_r && wr_mux && wr_addr == `CSR_ADDR_PIN_OUTPUT_A);
    no_result_c:   cover property (wr_en && wr_no_result && wr_addr == `CSR_ADDR_PIN_OUTPUT_A);
    par_shadow_c:  cover property (wr_go && run_r && wr_addr == `CSR_ADDR_LAUNCH_PARAMETER);

endmodule // core_special_registers

// >>> testbench/image_source_model.sv
// Main-memory image source that feeds the launch loader
`timescale 1ns/1ps

module image_source_model (
    input  wire logic        ref_clk,            // System clock
    input  wire logic        sys_rst,            // Synchronous reset
    input  wire logic        load_ready,         // Loader accepts word
    output logic             load_valid = 1'b0,  // Word offered
    output logic [31:0]      load_data = 32'h0   // Word value
);
    logic [8:0] idx_r  = 9'h0;
    logic [1:0] pace_r = 2'h0;
    logic       took_r = 1'b0;

    always @(posedge ref_clk) took_r <= load_valid & load_ready;

    // Word held until the edge that takes it, then inverted so stale data never looks valid
    always @(negedge ref_clk) begin
        if (sys_rst) begin
            load_valid <= 1'b0;
            idx_r      <= 9'h0;
        end else if (took_r) begin
            load_valid <= 1'b0;
            idx_r      <= idx_r + 9'h1;
            load_data  <= ~load_data;
        end else if (!load_ready) begin
            idx_r <= 9'h0;
        end else if (!load_valid) begin
            pace_r <= pace_r + 2'h1;
            // Skips one slot in four, so words come both promptly and late
            if (pace_r != 2'h0) begin
                load_valid <= 1'b1;
                load_data  <= 32'h5a5a_0000 ^ {23'h0, idx_r};
            end
        end
    end
endmodule // image_source_model

// >>> testbench/testbench.sv
// Self-checking bench for the core special register bank
`timescale 1ns/1ps
`include "core_special_registers_params.svh"

module testbench;
    localparam logic [8:0] a_out = `CSR_ADDR_PIN_OUTPUT_A;
    localparam logic [8:0] a_pin_output_state_b = `CSR_ADDR_PIN_OUTPUT_B;
    localparam logic [8:0] a_par = `CSR_ADDR_LAUNCH_PARAMETER;
    logic ref_clk = 1'b0, sys_rst = 1'b1, launch_req = 1'b0, rd_en = 1'b0, wr_en = 1'b0;
    logic wr_no_result = 1'b0, wr_mux = 1'b0, rd_q = 1'b0;
    logic [15:0] launch_param = 16'h0;
    logic [8:0]  launch_len = 9'h0, src_addr = 9'h0, dst_addr = 9'h0, wr_addr = 9'h0, a;
    logic [31:0] wr_data = 32'h0, wr_mask = 32'h0, pin_dir = 32'h0, seed = 32'h0000_d81a;
    logic [31:0] exp_pin = 32'h0, par_exp, v, m;
    logic [1:0]  count_en = 2'h0;
    logic [63:0] freq_inc = 64'h0;
    logic [95:0] note;
    logic [95:0] notes[$];
    logic        load_valid, load_ready, core_run;
    logic [31:0] load_data, src_data, dst_data, pin_o, pin_oe;
    int          n_errors = 0, n_compared = 0, i, k;

    always #5 ref_clk = ~ref_clk;

    core_special_registers core_special_registers_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .launch_req(launch_req), .launch_param(launch_param), .launch_len(launch_len),
        .load_valid(load_valid), .load_data(load_data), .load_ready(load_ready), .core_run(core_run),
        .rd_en(rd_en), .src_addr(src_addr), .dst_addr(dst_addr), .src_data(src_data), .dst_data(dst_data),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_no_result(wr_no_result), .wr_mux(wr_mux),
        .wr_mask(wr_mask), .count_en(count_en), .freq_inc(freq_inc), .pin_dir(pin_dir), .pin_o(pin_o),
        .pin_oe(pin_oe));
    image_source_model image_source_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .load_ready(load_ready), .load_valid(load_valid), .load_data(load_data));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Fetch both operands; expectations queued for the watcher
    task automatic rd(input logic [8:0] s, input logic [8:0] d, input logic [31:0] es, input logic [31:0] ed);
        @(negedge ref_clk);
        rd_en = 1'b1;
        src_addr = s;
        dst_addr = d;
        notes.push_back({es, ed, exp_pin});
        @(negedge ref_clk);
        rd_en = 1'b0;
    endtask

    // Idle cycle after the write so the register has surely settled
    task automatic wr(input logic [8:0] ad, input logic [31:0] d, input logic nr, input logic mx,
                      input logic [31:0] mk);
        @(negedge ref_clk);
        {wr_en, wr_addr, wr_data, wr_no_result, wr_mux, wr_mask} = {1'b1, ad, d, nr, mx, mk};
        @(negedge ref_clk);
        wr_en = 1'b0;
        @(negedge ref_clk);
    endtask

    always @(posedge ref_clk) rd_q <= rd_en;

    always @(negedge ref_clk) begin
        if (rd_q === 1'b1) begin
            note = notes.pop_front();
            check(src_data, note[95:64]);
            check(dst_data, note[63:32]);
            check(pin_o, note[31:0]);
            check(pin_oe, pin_dir);
            check({31'h0, load_ready}, 32'h0);
        end
    end

    initial begin
        freq_inc = {rnd(), rnd()};
        pin_dir = rnd();
        repeat (5) @(negedge ref_clk);
        sys_rst = 1'b0;
        wr(a_out, rnd(), 1'b0, 1'b0, 32'h0);
        $display("test prelaunch write done");
        v = rnd();
        @(negedge ref_clk);
        {launch_req, launch_param, launch_len} = {1'b1, v[15:0], 9'h3};
        par_exp = {16'h0, v[15:2], 2'b00};
        @(negedge ref_clk);
        launch_req = 1'b0;
        for (i = 0; i < 200 && core_run !== 1'b1; i++) @(negedge ref_clk);
        check({31'h0, core_run}, 32'h1);
        rd(a_par, a_pin_output_state_b, par_exp, 32'h0);
        for (i = 0; i < 4; i++) rd(i[8:0], a_pin_output_state_b, 32'h5a5a_0000 ^ i, 32'h0);
        $display("test launch done");
        v = rnd();
        wr(a_out, v, 1'b0, 1'b0, 32'h0);
        exp_pin = v;
        rd(a_out, a_out, v, v);
        v = rnd();
        m = rnd();
        wr(a_out, v, 1'b0, 1'b1, m);
        exp_pin = (exp_pin & ~m) | (v & m);
        rd(a_out, a_out, exp_pin, exp_pin);
        wr(a_out, rnd(), 1'b1, 1'b0, 32'h0);
        wr(a_pin_output_state_b, rnd(), 1'b0, 1'b0, 32'h0);
        rd(a_pin_output_state_b, a_pin_output_state_b, 32'h0, 32'h0);
        rd(a_out, a_out, exp_pin, exp_pin);
        $display("test outputs done");
        v = rnd();
        wr(a_par, v, 1'b0, 1'b0, 32'h0);
        rd(a_par, a_par, par_exp, v);
        $display("test parameter shadow done");
        for (k = 0; k < 2; k++) begin
            a = k ? `CSR_ADDR_PHASE_B : `CSR_ADDR_PHASE_A;
            v = rnd();
            wr(a, v, 1'b0, 1'b0, 32'h0);
            rd(a, a, v, v);
            @(negedge ref_clk);
            count_en[k] = 1'b1;
            repeat (5 + k) @(negedge ref_clk);
            count_en = 2'h0;
            rd(a, a, v + (5 + k) * freq_inc[k*32+:32], v);
        end
        $display("test phase counters done");
        repeat (3) @(negedge ref_clk);
        tally_and_finish();
    end

    initial begin
        #50us;
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule // testbench
